//--- rtl/fsw_dev.sv
/*
 Device end: write enable latch, busy reporting, reset-enable bit,
 active status monitor and status writes over an SPI slave (mode 0/3).
 Assumes the program/erase engine shares clk_in and reports ends by pulses.
*/
// Summary of operation
// - latch clear rejects program, erase, protect, status writes
// - latch is cleared at power-up and reset
// - completed or aborted write operations clear the latch
// - sequential program end or abort clears latch
// - software reset command leaves latch alone
// - incomplete or unknown opcode keeps latch set
// - busy flag reflects engine, readable in status
// - host keeps reading status until busy falls
// - reset command only honoured while reset-enable set
// - reset-enable only changed by status byte two write
// - status byte two: reset-enable bit4, busy bit0
// - status byte two write touches bit4 only
// - host starts monitoring with select and opcode 25h
// - serial input after 25h opcode is ignored
// - monitor drives live busy while select held
// - select release ends monitor, output released
// - status write is opcode 01h plus one byte
// - data bit7 lock, bits5..2 global request
// - select release applies lock and clears latch
// - short data byte aborts, latch still cleared
// - protect pin asserted: lock may only be set
// - lock set blocks sector protect and unprotect
// - byte two write is 31h, needs latch, clears it
`timescale 1ns/1ps
module fsw_dev
    import fsw_pkg::*;
(
    input wire logic clk_in,
    input wire logic reset_n_in,
    fsw_if.dev bus,
    input wire logic busy_in,
    input wire logic op_end_in,
    input wire logic seq_end_in,
    output logic wel_out,
    output logic lock_out,
    output logic reset_cmd_enable_out,
    output logic [7:0] status2_out,
    output logic op_start_out,
    output logic [7:0] op_code_out,
    output logic glob_strobe_out,
    output logic [3:0] glob_req_out,
    output logic glob_prior_lock_out,
    output logic soft_reset_out
);
    localparam int NPIN = 5;

    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] sync1_q;
    logic [NPIN-1:0] sync2_q;
    logic [NPIN-1:0] sync3_q;
    logic sck_s, cs_n_s, si_s, wp_n_s, hold_n_s;
    logic sck_rise, sck_fall, cs_fall, cs_rise, hold_fall;
    logic [7:0] rx_byte;
    logic [7:0] status2;

    fsw_dev_state_t st_q, st_d;
    logic [2:0] bit_q, bit_d;
    logic [7:0] sh_q, sh_d;
    logic [7:0] op_q, op_d;
    logic [7:0] dat_q, dat_d;
    logic datok_q, datok_d;
    logic [7:0] out_q, out_d;
    logic so_q, so_d;
    logic oe_n_q, oe_n_d;
    logic wel_q, wel_d;
    logic lock_q, lock_d;
    logic reset_cmd_enable_q, reset_cmd_enable_d;
    logic start_q, start_d;
    logic [7:0] code_q, code_d;
    logic glob_q, glob_d;
    logic [3:0] greq_q, greq_d;
    logic prior_q, prior_d;
    logic srst_q, srst_d;

    // commands that need the latch and end by clearing it
    function automatic logic is_write_op(input logic [7:0] op);
        case (op)
            `FSW_OP_WSR, `FSW_OP_WSR2, `FSW_OP_PROG, `FSW_OP_ERASE_4K,
            `FSW_OP_ERASE_32K, `FSW_OP_ERASE_64K, `FSW_OP_CHIP_ERASE,
            `FSW_OP_PROTECT, `FSW_OP_UNPROTECT: is_write_op = 1'b1;
            default: is_write_op = 1'b0;
        endcase
    endfunction

    // pins come from another clock: two flops, third only for edges
    assign pin_raw = {bus.hold_n, bus.wp_n, bus.si, bus.cs_n, bus.sck};
    genvar g;
    generate
        for (g = 0; g < NPIN; g++) begin : g_sync
            always_ff @(posedge clk_in or negedge reset_n_in) begin
                if (!reset_n_in) begin
                    // idle levels: clock low, the rest high, no false edge
                    sync1_q[g] <= (g != 0);
                    sync2_q[g] <= (g != 0);
                    sync3_q[g] <= (g != 0);
                end else begin
                    sync1_q[g] <= pin_raw[g];
                    sync2_q[g] <= sync1_q[g];
                    sync3_q[g] <= sync2_q[g];
                end
            end
        end
    endgenerate

    assign sck_s = sync2_q[0];
    assign cs_n_s = sync2_q[1];
    assign si_s = sync2_q[2];
    assign wp_n_s = sync2_q[3];
    assign hold_n_s = sync2_q[4];
    assign sck_rise = sck_s & ~sync3_q[0];
    assign sck_fall = ~sck_s & sync3_q[0];
    assign cs_fall = ~cs_n_s & sync3_q[1];
    assign cs_rise = cs_n_s & ~sync3_q[1];
    assign hold_fall = ~hold_n_s & sync3_q[4];
    assign rx_byte = {sh_q[6:0], si_s};

    always_comb begin
        status2 = 8'h00; // reserved bits read zero
        status2[`FSW_SB2_RESET_CMD_ENABLE_BIT] = reset_cmd_enable_q;
        status2[`FSW_SB2_BUSY_BIT] = busy_in;
    end

    always_comb begin
        st_d = st_q;
        bit_d = bit_q;
        sh_d = sh_q;
        op_d = op_q;
        dat_d = dat_q;
        datok_d = datok_q;
        out_d = out_q;
        so_d = so_q;
        oe_n_d = oe_n_q;
        wel_d = wel_q;
        lock_d = lock_q;
        reset_cmd_enable_d = reset_cmd_enable_q;
        start_d = 1'b0;
        code_d = code_q;
        glob_d = 1'b0;
        greq_d = greq_q;
        prior_d = prior_q;
        srst_d = 1'b0;
        if (op_end_in) begin
            wel_d = 1'b0;
        end
        if (seq_end_in) begin
            wel_d = 1'b0;
        end
        if (cs_fall) begin
            st_d = FSW_S_OPC;
            bit_d = 3'h0;
            datok_d = 1'b0;
        end else if (cs_rise) begin
            st_d = FSW_S_IDLE;
            oe_n_d = 1'b1;
            // still in opcode phase: nothing happens, latch kept
            if (st_q != FSW_S_IDLE && st_q != FSW_S_OPC) begin
                case (op_q)
                    `FSW_OP_WREN: begin
                        wel_d = 1'b1;
                    end
                    `FSW_OP_WRDI: begin
                        wel_d = 1'b0;
                    end
                    `FSW_OP_WSR: begin
                        wel_d = 1'b0;
                        // clearing the lock with protect pin low is void
                        if (wel_q && datok_q &&
                            (wp_n_s || dat_q[`FSW_WSR_LOCK_BIT])) begin
                            lock_d = dat_q[`FSW_WSR_LOCK_BIT];
                            glob_d = 1'b1;
                            greq_d = dat_q[`FSW_WSR_GREQ_HI:`FSW_WSR_GREQ_LO];
                            prior_d = lock_q;
                        end
                    end
                    `FSW_OP_WSR2: begin
                        wel_d = 1'b0;
                        // needs full byte on a byte boundary
                        if (wel_q && datok_q && bit_q == 3'h0) begin
                            reset_cmd_enable_d = dat_q[`FSW_SB2_RESET_CMD_ENABLE_BIT];
                        end
                    end
                    `FSW_OP_PROTECT, `FSW_OP_UNPROTECT: begin
                        if (wel_q && !lock_q) begin
                            start_d = 1'b1;
                            code_d = op_q;
                        end
                    end
                    `FSW_OP_SOFT_RST: begin
                        // latch and reset-enable untouched
                        srst_d = reset_cmd_enable_q;
                    end
                    default: begin
                        if (wel_q && is_write_op(op_q)) begin
                            start_d = 1'b1;
                            code_d = op_q;
                        end
                    end
                endcase
            end
        end else if (!cs_n_s) begin
            if (hold_fall && st_q != FSW_S_IDLE && st_q != FSW_S_OPC &&
                is_write_op(op_q)) begin
                wel_d = 1'b0; // hold aborts the command
                st_d = FSW_S_IDLE;
                oe_n_d = 1'b1;
            end else begin
                if (sck_rise && st_q != FSW_S_IDLE) begin
                    sh_d = rx_byte;
                    bit_d = bit_q + 3'h1;
                    if (bit_q == 3'h7) begin
                        case (st_q)
                            FSW_S_OPC: begin
                                op_d = rx_byte;
                                case (rx_byte)
                                    // later input bits are don't-care
                                    `FSW_OP_ASI: st_d = FSW_S_ASI;
                                    `FSW_OP_RDSR2: begin
                                        st_d = FSW_S_RDSR;
                                        out_d = status2;
                                    end
                                    `FSW_OP_WSR, `FSW_OP_WSR2:
                                        st_d = FSW_S_DATA;
                                    default: st_d = FSW_S_SKIP;
                                endcase
                            end
                            FSW_S_DATA: begin
                                dat_d = rx_byte;
                                datok_d = 1'b1;
                                st_d = FSW_S_SKIP; // extra bytes ignored
                            end
                            FSW_S_RDSR: out_d = status2; // fresh busy
                            default: ;
                        endcase
                    end
                end
                if (sck_fall && st_q == FSW_S_RDSR) begin
                    so_d = out_q[7];
                    out_d = {out_q[6:0], 1'b0};
                    oe_n_d = 1'b0;
                end
                if (st_q == FSW_S_ASI) begin
                    // live busy, no clock needed
                    so_d = busy_in;
                    oe_n_d = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            st_q <= FSW_S_IDLE;
            bit_q <= 3'h0;
            sh_q <= 8'h00;
            op_q <= 8'h00;
            dat_q <= 8'h00;
            datok_q <= 1'b0;
            out_q <= 8'h00;
            so_q <= 1'b0;
            oe_n_q <= 1'b1;
            wel_q <= `FSW_WEL_RST;
            lock_q <= `FSW_LOCK_RST;
            reset_cmd_enable_q <= `FSW_RESET_CMD_ENABLE_RST;
            start_q <= 1'b0;
            code_q <= 8'h00;
            glob_q <= 1'b0;
            greq_q <= 4'h0;
            prior_q <= 1'b0;
            srst_q <= 1'b0;
        end else begin
            st_q <= st_d;
            bit_q <= bit_d;
            sh_q <= sh_d;
            op_q <= op_d;
            dat_q <= dat_d;
            datok_q <= datok_d;
            out_q <= out_d;
            so_q <= so_d;
            oe_n_q <= oe_n_d;
            wel_q <= wel_d;
            lock_q <= lock_d;
            reset_cmd_enable_q <= reset_cmd_enable_d;
            start_q <= start_d;
            code_q <= code_d;
            glob_q <= glob_d;
            greq_q <= greq_d;
            prior_q <= prior_d;
            srst_q <= srst_d;
        end
    end

    assign bus.so = so_q;
    assign bus.so_oe_n = oe_n_q;
    assign wel_out = wel_q;
    assign lock_out = lock_q;
    assign reset_cmd_enable_out = reset_cmd_enable_q;
    assign status2_out = status2;
    assign op_start_out = start_q;
    assign op_code_out = code_q;
    assign glob_strobe_out = glob_q;
    assign glob_req_out = greq_q;
    assign glob_prior_lock_out = prior_q;
    assign soft_reset_out = srst_q;
endmodule

//--- rtl/fsw_map.svh
/*
 Register layout, opcodes and timing counts for the flash status and
 write-control block. Assumes inclusion by the package and both ends.
*/
`ifndef FSW_MAP_SVH
`define FSW_MAP_SVH

// opcodes
`define FSW_OP_WSR        8'h01
`define FSW_OP_WSR2       8'h31
`define FSW_OP_ASI        8'h25
`define FSW_OP_RDSR2      8'h35
`define FSW_OP_WREN       8'h06
`define FSW_OP_WRDI       8'h04
`define FSW_OP_PROG       8'h02
`define FSW_OP_ERASE_4K   8'h20
`define FSW_OP_ERASE_32K  8'h52
`define FSW_OP_ERASE_64K  8'hd8
`define FSW_OP_CHIP_ERASE 8'hc7
`define FSW_OP_PROTECT    8'h36
`define FSW_OP_UNPROTECT  8'h39
`define FSW_OP_SOFT_RST   8'hf0

// status byte two fields
`define FSW_SB2_RESET_CMD_ENABLE_BIT  4
`define FSW_SB2_BUSY_BIT  0

// status write data fields
`define FSW_WSR_LOCK_BIT  7
`define FSW_WSR_GREQ_HI   5
`define FSW_WSR_GREQ_LO   2

// reset values
`define FSW_WEL_RST       1'b0
`define FSW_LOCK_RST      1'b0
`define FSW_RESET_CMD_ENABLE_RST      1'b0

// host serial clock: 125 ns requested, 120 ns produced (half period rounds down to 12 cycles) at a 5 ns system clock
`define FSW_SCK_PERIOD_NS 125
`define FSW_CLK_PERIOD_NS 5
`define FSW_HALF_CYC ((`FSW_SCK_PERIOD_NS / `FSW_CLK_PERIOD_NS) / 2)

`endif

//--- rtl/fsw_pkg.sv
/*
 Types shared by the flash status block ends.
 Assumes fsw_map.svh is on the include path.
*/
package fsw_pkg;
    `include "fsw_map.svh"

    typedef enum logic [2:0] {
        FSW_S_IDLE = 3'h0,
        FSW_S_OPC = 3'h1,
        FSW_S_DATA = 3'h3,
        FSW_S_SKIP = 3'h2,
        FSW_S_RDSR = 3'h6,
        FSW_S_ASI = 3'h7
    } fsw_dev_state_t;

    typedef enum logic [2:0] {
        FSW_H_IDLE = 3'h0,
        FSW_H_SETUP = 3'h1,
        FSW_H_SHIFT = 3'h3,
        FSW_H_ASI = 3'h2,
        FSW_H_END = 3'h6,
        FSW_H_GAP = 3'h4
    } fsw_host_state_t;

    typedef enum logic [1:0] {
        FSW_M_WRITE = 2'h0,
        FSW_M_READ = 2'h1,
        FSW_M_POLL = 2'h2,
        FSW_M_ASI = 2'h3
    } fsw_host_mode_t;
endpackage

//--- rtl/fsw_if.sv
/*
 Serial link between the flash status device end and its host end.
 Assumes a board pull-up on the serial output while nobody drives it.
*/
`timescale 1ns/1ps
interface fsw_if;
    logic sck;
    logic cs_n;
    logic si;
    logic so;
    logic so_oe_n;
    logic wp_n;
    logic hold_n;
    logic so_line;

    // pull-up seen when the device releases the line
    assign so_line = so_oe_n ? 1'b1 : so;

    modport dev (
        input sck,
        input cs_n,
        input si,
        input wp_n,
        input hold_n,
        output so,
        output so_oe_n
    );
    modport host (
        output sck,
        output cs_n,
        output si,
        output wp_n,
        output hold_n,
        input so_line
    );
endinterface

//--- rtl/fsw_host.sv
/*
 Host end: mode 0 SPI master sending one opcode, an optional data byte,
 then reading, polling busy or watching the active status line.
 Assumes the device end on the far side of fsw_if.
*/
`timescale 1ns/1ps
module fsw_host
    import fsw_pkg::*;
#(
    parameter int HALF_CYC = `FSW_HALF_CYC
)
(
    input wire logic clk_in,
    input wire logic reset_n_in,
    fsw_if.host bus,
    input wire logic cmd_valid_in,
    output logic cmd_ready_out,
    input wire logic [7:0] cmd_op_in,
    input wire logic [7:0] cmd_data_in,
    input wire logic cmd_has_data_in,
    input wire fsw_host_mode_t cmd_mode_in,
    input wire logic wp_n_in,
    input wire logic hold_n_in,
    output logic rsp_valid_out,
    output logic [7:0] rsp_data_out
);
    logic so1_q, so2_q;
    logic tick;
    logic [7:0] div_q, div_d;
    fsw_host_state_t st_q, st_d;
    fsw_host_mode_t mode_q, mode_d;
    logic sck_q, sck_d;
    logic cs_n_q, cs_n_d;
    logic si_q, si_d;
    logic [15:0] tx_q, tx_d;
    logic [4:0] nb_q, nb_d;
    logic [7:0] rx_q, rx_d;
    logic rv_q, rv_d;
    logic [7:0] rd_q, rd_d;

    assign tick = (div_q == 8'(HALF_CYC - 1));

    always_comb begin
        div_d = tick ? 8'h00 : div_q + 8'h01;
        st_d = st_q;
        mode_d = mode_q;
        sck_d = sck_q;
        cs_n_d = cs_n_q;
        si_d = si_q;
        tx_d = tx_q;
        nb_d = nb_q;
        rx_d = rx_q;
        rv_d = 1'b0;
        rd_d = rd_q;
        case (st_q)
            FSW_H_IDLE: begin
                if (cmd_valid_in) begin
                    tx_d = {cmd_op_in, cmd_data_in};
                    nb_d = cmd_has_data_in ? 5'd16 : 5'd8;
                    if (cmd_mode_in == FSW_M_READ ||
                        cmd_mode_in == FSW_M_POLL) begin
                        nb_d = nb_d + 5'd8;
                    end
                    mode_d = cmd_mode_in;
                    cs_n_d = 1'b0;
                    div_d = 8'h00;
                    st_d = FSW_H_SETUP;
                end
            end
            FSW_H_SETUP: begin
                if (tick) begin
                    si_d = tx_q[15];
                    st_d = FSW_H_SHIFT;
                end
            end
            FSW_H_SHIFT: begin
                if (tick && !sck_q) begin
                    sck_d = 1'b1;
                    rx_d = {rx_q[6:0], so2_q};
                end else if (tick) begin
                    sck_d = 1'b0;
                    tx_d = {tx_q[14:0], 1'b0};
                    si_d = tx_q[14];
                    nb_d = nb_q - 5'd1;
                    if (nb_q == 5'd1) begin
                        case (mode_q)
                            FSW_M_READ: begin
                                rv_d = 1'b1;
                                rd_d = rx_q;
                                st_d = FSW_H_END;
                            end
                            FSW_M_POLL: begin
                                // keep clocking while busy
                                if (rx_q[`FSW_SB2_BUSY_BIT]) begin
                                    nb_d = 5'd8;
                                end else begin
                                    rv_d = 1'b1;
                                    rd_d = rx_q;
                                    st_d = FSW_H_END;
                                end
                            end
                            // mode 0: no dummy bit after 25h
                            FSW_M_ASI: st_d = FSW_H_ASI;
                            default: st_d = FSW_H_END;
                        endcase
                    end
                end
            end
            FSW_H_ASI: begin
                if (!so2_q) begin
                    rv_d = 1'b1;
                    rd_d = 8'h00;
                    st_d = FSW_H_END;
                end
            end
            FSW_H_END: begin
                if (tick) begin
                    cs_n_d = 1'b1;
                    st_d = FSW_H_GAP;
                end
            end
            FSW_H_GAP: begin
                if (tick) begin
                    st_d = FSW_H_IDLE;
                end
            end
            default: st_d = FSW_H_IDLE;
        endcase
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            so1_q <= 1'b1;
            so2_q <= 1'b1;
            div_q <= 8'h00;
            st_q <= FSW_H_IDLE;
            mode_q <= FSW_M_WRITE;
            sck_q <= 1'b0;
            cs_n_q <= 1'b1;
            si_q <= 1'b0;
            tx_q <= 16'h0000;
            nb_q <= 5'h00;
            rx_q <= 8'h00;
            rv_q <= 1'b0;
            rd_q <= 8'h00;
        end else begin
            so1_q <= bus.so_line;
            so2_q <= so1_q;
            div_q <= div_d;
            st_q <= st_d;
            mode_q <= mode_d;
            sck_q <= sck_d;
            cs_n_q <= cs_n_d;
            si_q <= si_d;
            tx_q <= tx_d;
            nb_q <= nb_d;
            rx_q <= rx_d;
            rv_q <= rv_d;
            rd_q <= rd_d;
        end
    end

    assign cmd_ready_out = (st_q == FSW_H_IDLE);
    assign bus.sck = sck_q;
    assign bus.cs_n = cs_n_q;
    assign bus.si = si_q;
    assign bus.wp_n = wp_n_in;
    assign bus.hold_n = hold_n_in;
    assign rsp_valid_out = rv_q;
    assign rsp_data_out = rd_q;
endmodule

//--- sim/fsw_assertions.sv
/*
 Wire checker for the flash status link between host and device ends.
 Assumes the bench wires it to the fsw_if signals beside the link.
*/
`timescale 1ns/1ps
module fsw_assertions (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    input wire logic so_oe_n
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    sequence s_hi;
        sck [*5];
    endsequence
    sequence s_lo;
        !sck [*5];
    endsequence
    out_release_a: assert property ($rose(cs_n) |-> ##[1:5] so_oe_n)
        else $error("output not released after select");
    idle_float_a: assert property (cs_n [*6] |-> so_oe_n)
        else $error("output driven between frames");
    drive_frame_a: assert property ($fell(so_oe_n) |-> !cs_n)
        else $error("output driven without select");
    start_low_a: assert property ($fell(cs_n) |-> !sck)
        else $error("select fell with clock high");
    clk_idle_a: assert property (cs_n |-> !sck)
        else $error("clock moved outside frame");
    in_frame_a: assert property ($rose(sck) |-> !cs_n)
        else $error("clock edge without select");
    si_hold_a: assert property (sck && $past(sck) |-> $stable(si))
        else $error("data changed while clock high");
    high_len_a: assert property ($rose(sck) |-> s_hi)
        else $error("clock high too short");
    low_len_a: assert property ($fell(sck) |-> s_lo)
        else $error("clock low too short");
endmodule

//--- sim/tb.sv
/*
 Self-checking bench: host end and device end joined by fsw_if.
 Assumes the rtl package, interface and both ends are compiled first.
*/
`timescale 1ns/1ps
module tb;
    import fsw_pkg::*;
    logic clk_in = 0, reset_n_in = 0, v = 0, hd = 0, busy = 0;
    logic oe = 0, se = 0, wp = 1, hn = 1;
    logic [7:0] op = 0, dt = 0, d;
    fsw_host_mode_t md = FSW_M_WRITE;
    logic rdy, rv, write_enable_latch, lock, reset_cmd_enable, ost, gs, gpl, srst;
    logic [7:0] rd, st2, ocode;
    logic [3:0] greq;
    int err_count = 0, compares = 0, cg = 0, co = 0, cr = 0;
    int m_wel = 0, m_lock = 0, m_reset_cmd_enable = 0, ng = 0, no = 0, pl;
    fsw_if bus();
    fsw_dev u_fsw_dev(.clk_in(clk_in), .reset_n_in(reset_n_in),
        .bus(bus), .busy_in(busy), .op_end_in(oe), .seq_end_in(se),
        .wel_out(write_enable_latch), .lock_out(lock), .reset_cmd_enable_out(reset_cmd_enable),
        .status2_out(st2), .op_start_out(ost), .op_code_out(ocode),
        .glob_strobe_out(gs), .glob_req_out(greq),
        .glob_prior_lock_out(gpl), .soft_reset_out(srst));
    fsw_host #(.HALF_CYC(8)) u_fsw_host(.clk_in(clk_in),
        .reset_n_in(reset_n_in), .bus(bus), .cmd_valid_in(v),
        .cmd_ready_out(rdy), .cmd_op_in(op), .cmd_data_in(dt),
        .cmd_has_data_in(hd), .cmd_mode_in(md), .wp_n_in(wp),
        .hold_n_in(hn), .rsp_valid_out(rv), .rsp_data_out(rd));
    fsw_assertions u_fsw_assertions(.clk_in(clk_in),
        .reset_n_in(reset_n_in), .sck(bus.sck), .cs_n(bus.cs_n),
        .si(bus.si), .so_oe_n(bus.so_oe_n));
    initial begin
        forever #2.5 clk_in = ~clk_in;
    end
    // pulse counters, compared against the model's tallies
    always @(posedge clk_in) begin
        cg <= cg + gs;
        co <= co + ost;
        cr <= cr + srst;
    end
    task conclude;
        if (err_count == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %0t %h %h", $time, g, e);
        end
    endtask
    // one frame; waits for the host to go idle, then lets effects land
    task w(input logic [7:0] o, input logic [7:0] x, input logic h,
        input fsw_host_mode_t m);
        int i;
        op = o;
        dt = x;
        hd = h;
        md = m;
        v = 1;
        @(posedge clk_in);
        #1 v = 0;
        for (i = 0; i < 30000 && !rdy; i++) begin
            @(posedge clk_in);
            #1;
        end
        repeat (8) @(posedge clk_in);
        #1;
    endtask
    task wren;
        w(8'h06, 8'h00, 0, FSW_M_WRITE);
        m_wel = 1;
    endtask
    task rs;
        w(8'h35, 8'h00, 0, FSW_M_READ);
        chk(rd, {3'h0, m_reset_cmd_enable[0], 3'h0, busy});
    endtask
    task pls(input logic s);
        if (s) oe = 1; else se = 1;
        @(posedge clk_in);
        #1 oe = 0;
        se = 0;
        repeat (3) @(posedge clk_in);
        #1 m_wel = 0;
    endtask
    initial begin
        #(5 * 80000);
        err_count++;
        conclude();
    end
    initial begin
        void'($urandom(32'hbb34b554));
        repeat (6) @(posedge clk_in);
        #1 reset_n_in = 1;
        repeat (6) @(posedge clk_in);
        #1 chk(write_enable_latch, 0);
        rs();
        w(8'h01, 8'h80, 1, FSW_M_WRITE);
        chk(lock, 0);
        w(8'h02, 8'h00, 1, FSW_M_WRITE);
        chk(co, no);
        wren();
        w(8'haa, 8'h00, 0, FSW_M_WRITE);
        chk(write_enable_latch, 1);
        w(8'h04, 8'h00, 0, FSW_M_WRITE);
        chk(write_enable_latch, 0);
        for (int i = 0; i < 8; i++) begin
            wren();
            d = 8'($urandom);
            wp = (i < 6) ? 1'($urandom) : 1'b1;
            if (i == 7) d[7] = 1;
            w(8'h01, d, 1, FSW_M_WRITE);
            pl = m_lock;
            if (wp || d[7]) begin
                m_lock = d[7];
                ng++;
                chk(greq, d[5:2]);
                chk(gpl, pl[0]);
            end
            chk(lock, m_lock);
            chk(write_enable_latch, 0);
            chk(cg, ng);
        end
        wren();
        w(8'h36, 8'h00, 1, FSW_M_WRITE);
        chk(co, no);
        chk(write_enable_latch, 1);
        w(8'h02, 8'h00, 1, FSW_M_WRITE);
        no++;
        chk(co, no);
        chk(ocode, 8'h02);
        pls(1);
        chk(write_enable_latch, 0);
        wren();
        pls(0);
        chk(write_enable_latch, 0);
        wren();
        fork
            w(8'h02, 8'h00, 1, FSW_M_WRITE);
            begin
                repeat (200) @(posedge clk_in);
                #1 hn = 0;
                repeat (2) @(posedge clk_in);
                #1 hn = 1;
            end
        join
        chk(write_enable_latch, 0);
        chk(co, no);
        w(8'hf0, 8'h00, 0, FSW_M_WRITE);
        chk(cr, 0);
        for (int i = 0; i < 2; i++) begin
            wren();
            d = 8'($urandom);
            d[4] = i[0];
            w(8'h31, d, 1, FSW_M_WRITE);
            m_reset_cmd_enable = i;
            chk(write_enable_latch, 0);
            rs();
        end
        wren();
        w(8'hf0, 8'h00, 0, FSW_M_WRITE);
        chk(cr, 1);
        chk(reset_cmd_enable, 1);
        chk(write_enable_latch, 1);
        busy = 1;
        rs();
        fork
            w(8'h35, 8'h00, 0, FSW_M_POLL);
            begin
                repeat (600) @(posedge clk_in);
                #1 busy = 0;
            end
        join
        chk(rd, {3'h0, m_reset_cmd_enable[0], 4'h0});
        busy = 1;
        fork
            w(8'h25, 8'h00, 0, FSW_M_ASI);
            begin
                repeat (400) @(posedge clk_in);
                #1 chk(bus.so_line, 1);
                busy = 0;
            end
        join
        chk(rd, 8'h00);
        conclude();
    end
endmodule
